// File: hw/dcc_pkg.sv
/*
 * Constants and types for the dual comparator control block.
 * Assumes an APB master with 32-bit data and a 50 MHz system clock.
 */
package dcc_pkg;

	// ************************************************
	// Register map (word indices and byte addresses)
	// ************************************************
	localparam logic [11:0] COMPARATOR0_CONTROL_IDX  = 12'h009e;
	localparam logic [11:0] COMPARATOR1_CONTROL_IDX  = 12'h009f;
	localparam logic [11:0] INT_STATUS_IDX           = 12'h00a0;
	localparam logic [11:0] INT_MASK_IDX             = 12'h00a1;
	localparam logic [11:0] RESET_CFG_IDX            = 12'h00a2;
	localparam logic [11:0] PIN_CFG_IDX              = 12'h00a3;
	localparam logic [13:0] COMPARATOR0_CONTROL_ADDR = {COMPARATOR0_CONTROL_IDX, 2'b00};
	localparam logic [13:0] COMPARATOR1_CONTROL_ADDR = {COMPARATOR1_CONTROL_IDX, 2'b00};
	localparam logic [13:0] INT_STATUS_ADDR          = {INT_STATUS_IDX, 2'b00};
	localparam logic [13:0] INT_MASK_ADDR            = {INT_MASK_IDX, 2'b00};
	localparam logic [13:0] RESET_CFG_ADDR           = {RESET_CFG_IDX, 2'b00};
	localparam logic [13:0] PIN_CFG_ADDR             = {PIN_CFG_IDX, 2'b00};

	// ************************************************
	// Control register fields
	// ************************************************
	localparam int          BIT_ENABLE    = 7;
	localparam int          BIT_OUT_STATE = 6;
	localparam int          BIT_RISE_FLAG = 5;
	localparam int          BIT_FALL_FLAG = 4;
	localparam int          HYP_LSB       = 2;
	localparam int          HYN_LSB       = 0;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;

	// Status/mask layout: bit 2n rising, bit 2n+1 falling for comparator n
	localparam logic [3:0]  STATUS_RESET  = 4'h0;
	localparam logic [3:0]  MASK_RESET    = 4'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// ************************************************
	// Hysteresis codes
	// ************************************************
	typedef enum logic [1:0] {
		DCC_HYS_OFF   = 2'b00,
		DCC_HYS_2MV   = 2'b01,
		DCC_HYS_4MV   = 2'b10,
		DCC_HYS_10MV  = 2'b11
	} dcc_hys_t;

	typedef struct packed {
		logic     enable;
		dcc_hys_t hys_pos;
		dcc_hys_t hys_neg;
	} dcc_analog_t;

	// ************************************************
	// Timing
	// ************************************************
	localparam int POWER_ON_MS   = 20;
	localparam int CLK_HZ        = 50_000_000;
	localparam int POWER_ON_CYC  = POWER_ON_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		DCC_ST_IDLE   = 2'b00,
		DCC_ST_ACCESS = 2'b01
	} dcc_apb_state_t;

endpackage : dcc_pkg

// File: hw/dcc_top.sv
/*
 * Dual comparator control: two control registers, edge flags, interrupt,
 * reset request from comparator 0, pin drive for port 1 routing.
 * Assumes APB master, raw analog comparator outputs asynchronous.
 */
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dcc_top
	import dcc_pkg::*;
#(
	parameter int POWER_ON_CYCLES = dcc_pkg::POWER_ON_CYC
) (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [13:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [1:0]         cmp_raw,
	output dcc_pkg::dcc_analog_t    analog_cfg0,
	output dcc_pkg::dcc_analog_t    analog_cfg1,
	output logic      [1:0]         pin_out,
	output logic      [1:0]         pin_oe,
	output logic      [1:0]         stable,
	output logic                    irq,
	output logic                    reset_req
);
	import dcc_pkg::*;

	// ************************************************
	// Register storage
	// ************************************************
	logic [1:0]     en_ff;
	logic [1:0]     hyp_ff [2];
	logic [1:0]     hyn_ff [2];
	logic [3:0]     status_ff;
	logic [3:0]     mask_ff;
	logic           rst_en_ff;
	logic [1:0]     route_ff;
	logic [1:0]     pushpull_ff;
	logic [1:0]     sync1_ff;
	logic [1:0]     sync2_ff;
	logic [1:0]     prev_ff;
	logic [1:0]     valid_ff;
	logic [31:0]    cnt_ff [2];
	dcc_apb_state_t state_ff;
	logic           wr_en;
	logic [3:0]     edge_set;
	logic [3:0]     nxt_status;
	logic [7:0]     ctrl_rd [2];

	assign wr_en = psel && penable && pwrite && (state_ff == DCC_ST_ACCESS);

	// ************************************************
	// APB slave: one wait cycle, answer in the access phase
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_ff <= DCC_ST_IDLE;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			case (state_ff)
				DCC_ST_IDLE: begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					if (psel && penable) begin
						state_ff <= DCC_ST_ACCESS;
						pready   <= 1'b1;
					end
				end
				DCC_ST_ACCESS: begin
					state_ff <= DCC_ST_IDLE;
					pready   <= 1'b0;
				end
				default: state_ff <= DCC_ST_IDLE;
			endcase
		end
	end

	// Read data is built one cycle ahead so that it leaves a flip-flop
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ctrl_rd[i] = {en_ff[i], sync2_ff[i] & en_ff[i], status_ff[2*i],
				status_ff[2*i+1], hyp_ff[i], hyn_ff[i]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata <= UNMAPPED_DATA;
		end else if (psel && penable && !pwrite && state_ff == DCC_ST_IDLE) begin
			case (paddr)
				COMPARATOR0_CONTROL_ADDR: prdata <= {24'h00_0000, ctrl_rd[0]};
				COMPARATOR1_CONTROL_ADDR: prdata <= {24'h00_0000, ctrl_rd[1]};
				INT_STATUS_ADDR:          prdata <= {28'h000_0000, status_ff};
				INT_MASK_ADDR:            prdata <= {28'h000_0000, mask_ff};
				RESET_CFG_ADDR:           prdata <= {31'h0000_0000, rst_en_ff};
				PIN_CFG_ADDR: prdata <= {28'h000_0000, pushpull_ff, route_ff};
				default:                  prdata <= UNMAPPED_DATA;
			endcase
		end
	end

	// ************************************************
	// Control registers
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			en_ff       <= 2'b00;
			hyp_ff[0]   <= 2'b00;
			hyp_ff[1]   <= 2'b00;
			hyn_ff[0]   <= 2'b00;
			hyn_ff[1]   <= 2'b00;
			mask_ff     <= MASK_RESET;
			rst_en_ff   <= 1'b0;
			route_ff    <= 2'b00;
			pushpull_ff <= 2'b00;
		end else if (wr_en) begin
			for (int i = 0; i < 2; i++) begin
				if (paddr == (i == 0 ? COMPARATOR0_CONTROL_ADDR
						: COMPARATOR1_CONTROL_ADDR)) begin
					en_ff[i]  <= pwdata[BIT_ENABLE];
					hyp_ff[i] <= pwdata[HYP_LSB +: 2];
					hyn_ff[i] <= pwdata[HYN_LSB +: 2];
				end
			end
			if (paddr == INT_MASK_ADDR) begin
				mask_ff <= pwdata[3:0];
			end
			// Only comparator 0 has a reset path at all
			if (paddr == RESET_CFG_ADDR) begin
				rst_en_ff <= pwdata[0];
			end
			if (paddr == PIN_CFG_ADDR) begin
				route_ff    <= pwdata[1:0];
				pushpull_ff <= pwdata[3:2];
			end
		end
	end

	// ************************************************
	// Synchroniser and edge detection
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync1_ff <= 2'b00;
			sync2_ff <= 2'b00;
			prev_ff  <= 2'b00;
		end else begin
			sync1_ff <= cmp_raw;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// Disabled comparators raise no events
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			edge_set[2*i]   = en_ff[i] && sync2_ff[i] && !prev_ff[i];
			edge_set[2*i+1] = en_ff[i] && !sync2_ff[i] && prev_ff[i];
		end
	end

	// Flags live in the control registers and mirror at INT_STATUS;
	// writing zero to a control flag bit or one to a status bit clears it.
	// A new edge in the clearing cycle wins.
	always_comb begin
		nxt_status = status_ff;
		if (wr_en) begin
			for (int i = 0; i < 2; i++) begin
				if (paddr == (i == 0 ? COMPARATOR0_CONTROL_ADDR
						: COMPARATOR1_CONTROL_ADDR)) begin
					if (!pwdata[BIT_RISE_FLAG])
						nxt_status[2*i] = 1'b0;
					if (!pwdata[BIT_FALL_FLAG])
						nxt_status[2*i+1] = 1'b0;
				end
			end
			if (paddr == INT_STATUS_ADDR)
				nxt_status = nxt_status & ~pwdata[3:0];
		end
		nxt_status = nxt_status | edge_set;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_ff <= STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq         <= 1'b0;
			reset_req   <= 1'b0;
			pin_out     <= 2'b00;
			pin_oe      <= 2'b00;
			analog_cfg0 <= '0;
			analog_cfg1 <= '0;
		end else begin
			irq <= |(nxt_status & mask_ff & {en_ff[1], en_ff[1],
				en_ff[0], en_ff[0]});
			// Reset request only when the output is trusted as stable
			reset_req <= rst_en_ff && en_ff[0] && valid_ff[0]
				&& !sync2_ff[0];
			for (int i = 0; i < 2; i++) begin
				// Open drain drives only the low level
				pin_out[i] <= route_ff[i] && en_ff[i] && sync2_ff[i];
				pin_oe[i]  <= route_ff[i] && (pushpull_ff[i]
					|| !(en_ff[i] && sync2_ff[i]));
			end
			analog_cfg0 <= '{en_ff[0], dcc_hys_t'(hyp_ff[0]),
				dcc_hys_t'(hyn_ff[0])};
			analog_cfg1 <= '{en_ff[1], dcc_hys_t'(hyp_ff[1]),
				dcc_hys_t'(hyn_ff[1])};
		end
	end

	// ************************************************
	// Power-on settling timers
	// ************************************************
	// Hardware reports readiness and gates only reset_req on it; software still must wait
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_ff[0] <= 32'h0000_0000;
			cnt_ff[1] <= 32'h0000_0000;
			valid_ff  <= 2'b00;
			stable    <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!en_ff[i]) begin
					cnt_ff[i]   <= 32'h0000_0000;
					valid_ff[i] <= 1'b0;
				end else if (cnt_ff[i] < 32'(POWER_ON_CYCLES)) begin
					cnt_ff[i] <= cnt_ff[i] + 32'h0000_0001;
				end else begin
					valid_ff[i] <= 1'b1;
				end
			end
			stable <= valid_ff;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	property p_enable_follows;
		@(posedge ref_clk) disable iff (reset)
		(wr_en && paddr == COMPARATOR0_CONTROL_ADDR)
			|=> en_ff[0] == $past(pwdata[BIT_ENABLE]);
	endproperty
	a_enable_follows: assert property (p_enable_follows)
		else $error("enable bit not taken");

	property p_out_state;
		@(posedge ref_clk) disable iff (reset)
		en_ff[0] |-> ctrl_rd[0][BIT_OUT_STATE] == $past(cmp_raw[0], 2);
	endproperty
	a_out_state: assert property (p_out_state)
		else $error("output state bit wrong");

	sequence s_rise0;
		en_ff[0] && !prev_ff[0] && sync2_ff[0];
	endsequence
	property p_rise_sets;
		@(posedge ref_clk) disable iff (reset)
		s_rise0 |=> status_ff[0];
	endproperty
	a_rise_sets: assert property (p_rise_sets)
		else $error("rising flag not set");

	property p_fall_sets;
		@(posedge ref_clk) disable iff (reset)
		(en_ff[1] && prev_ff[1] && !sync2_ff[1]) |=> status_ff[3];
	endproperty
	a_fall_sets: assert property (p_fall_sets)
		else $error("falling flag not set");

	property p_sticky;
		@(posedge ref_clk) disable iff (reset)
		(status_ff[0] && !wr_en) |=> status_ff[0];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without write");

	property p_disabled_pin_low;
		@(posedge ref_clk) disable iff (reset)
		!en_ff[1] |-> (!edge_set[2] && !edge_set[3]) ##1 !pin_out[1];
	endproperty
	a_disabled_pin_low: assert property (p_disabled_pin_low)
		else $error("disabled comparator active");

	property p_hys_pass;
		@(posedge ref_clk) disable iff (reset)
		(wr_en && paddr == COMPARATOR0_CONTROL_ADDR) |-> ##2
			analog_cfg0.hys_pos == $past(pwdata[HYP_LSB +: 2], 2)
			&& analog_cfg0.hys_neg == $past(pwdata[HYN_LSB +: 2], 2);
	endproperty
	a_hys_pass: assert property (p_hys_pass)
		else $error("hysteresis code not passed");

	// Open drain may only pull low
	property p_od_no_high;
		@(posedge ref_clk) disable iff (reset)
		(route_ff[0] && !pushpull_ff[0]) |=> !(pin_oe[0] && pin_out[0]);
	endproperty
	a_od_no_high: assert property (p_od_no_high)
		else $error("open drain pin driven high");

	property p_reset_src;
		@(posedge ref_clk) disable iff (reset)
		reset_req |-> $past(rst_en_ff && en_ff[0] && !sync2_ff[0]);
	endproperty
	a_reset_src: assert property (p_reset_src)
		else $error("reset request without comparator 0 low");

	property p_rise_irq;
		@(posedge ref_clk) disable iff (reset)
		(en_ff[0] && mask_ff[0] && sync2_ff[0] && !prev_ff[0]) |=> irq;
	endproperty
	a_rise_irq: assert property (p_rise_irq)
		else $error("rising edge raised no interrupt");

	property p_sync_delay;
		@(posedge ref_clk) disable iff (reset)
		$rose(sync2_ff[0]) |-> $past(cmp_raw[0], 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("synchroniser depth wrong");

endmodule : dcc_top

`default_nettype wire

// File: test/dcc_top_tb_top.sv
/*
 * Self-checking bench for the dual comparator control block.
 * Assumes dcc_pkg and dcc_top are compiled first; APB master is this bench.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin \
	miscompares++; $display("MISMATCH %0t %s", $time, msg); end end

module dcc_top_tb_top;
	import dcc_pkg::*;

	// ************************************************
	// Signals
	// ************************************************
	logic                 ref_clk;
	logic                 reset;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [13:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic [1:0]           cmp_raw;
	dcc_analog_t          analog_cfg0;
	dcc_analog_t          analog_cfg1;
	logic [1:0]           pin_out;
	logic [1:0]           pin_oe;
	logic [1:0]           stable;
	logic                 irq;
	logic                 reset_req;
	int                   miscompares = 0;
	int                   checks      = 0;

	// Short power-on count keeps the run small
	dcc_top #(.POWER_ON_CYCLES(20)) dut_u (
		.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
		.analog_cfg0(analog_cfg0), .analog_cfg1(analog_cfg1),
		.pin_out(pin_out), .pin_oe(pin_oe), .stable(stable), .irq(irq),
		.reset_req(reset_req)
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ************************************************
	// Bus and helper tasks
	// ************************************************
	// Entered just after a rising edge; leaves one idle cycle behind it
	task automatic apb(input logic wr, input logic [13:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		`CHK(pslverr, 1'b0, "slave error")
		if (n >= 50) `CHK(1'b0, 1'b1, "no pready")
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [13:0] a, input logic [31:0] e,
			input string m);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		`CHK(q, e, m)
	endtask : rd

	task automatic wait_stable(input logic [1:0] s);
		int n;
		n = 0;
		while (stable !== s && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(stable, s, "stable timeout")
	endtask : wait_stable

	task automatic raw(input logic [1:0] v);
		cmp_raw <= v;
		repeat (6) @(posedge ref_clk);
	endtask : raw

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_reset_values;
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_0000, "ctrl0 reset");
		rd(COMPARATOR1_CONTROL_ADDR, 32'h0000_0000, "ctrl1 reset");
		rd(INT_STATUS_ADDR, 32'h0000_0000, "status reset");
		rd(INT_MASK_ADDR, 32'h0000_0000, "mask reset");
		rd(RESET_CFG_ADDR, 32'h0000_0000, "rstcfg reset");
		rd(PIN_CFG_ADDR, 32'h0000_0000, "pincfg reset");
		wr(14'h0000, 32'hffff_ffff);
		rd(14'h0000, UNMAPPED_DATA, "unmapped read");
		`CHK(analog_cfg0, 5'b0_0000, "cfg0 reset")
		// Bit 6 read-only, flags cannot be set by writing a one
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_007f);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_000f, "ctrl0 ro bits");
	endtask : t_reset_values

	task automatic t_hysteresis;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(COMPARATOR0_CONTROL_ADDR, {24'h0, 4'h8, c, ~c});
			wr(COMPARATOR1_CONTROL_ADDR, {24'h0, 4'h0, ~c, c});
			// Analog config trails the register by one cycle
			@(posedge ref_clk);
			`CHK(analog_cfg0, {1'b1, c, ~c}, "cfg0 codes")
			`CHK(analog_cfg1, {1'b0, ~c, c}, "cfg1 codes")
			rd(COMPARATOR0_CONTROL_ADDR, {24'h0, 4'h8, c, ~c}, "ctrl0 rb");
		end
	endtask : t_hysteresis

	task automatic t_edges;
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_0080);
		wr(COMPARATOR1_CONTROL_ADDR, 32'h0000_0080);
		wait_stable(2'b11);
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_0080);
		wr(COMPARATOR1_CONTROL_ADDR, 32'h0000_0080);
		wr(INT_STATUS_ADDR, 32'h0000_000f);
		wr(INT_MASK_ADDR, 32'h0000_000f);
		raw(2'b01);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_00e0, "rise ctrl0");
		rd(INT_STATUS_ADDR, 32'h0000_0001, "rise status");
		`CHK(irq, 1'b1, "rise irq")
		wr(INT_MASK_ADDR, 32'h0000_0000);
		@(posedge ref_clk);
		`CHK(irq, 1'b0, "mask no effect")
		wr(INT_MASK_ADDR, 32'h0000_000f);
		raw(2'b00);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_00b0, "fall ctrl0");
		rd(INT_STATUS_ADDR, 32'h0000_0003, "fall status");
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_00b0);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_00b0, "flags keep");
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_0090);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_0090, "rise clear");
		wr(INT_STATUS_ADDR, 32'h0000_0001);
		rd(INT_STATUS_ADDR, 32'h0000_0002, "w1c status");
		wr(INT_STATUS_ADDR, 32'h0000_0002);
		`CHK(irq, 1'b0, "irq clear")
		raw(2'b10);
		rd(COMPARATOR1_CONTROL_ADDR, 32'h0000_00e0, "rise ctrl1");
		raw(2'b00);
		rd(INT_STATUS_ADDR, 32'h0000_000c, "cmp1 status");
		`CHK(irq, 1'b1, "irq cmp1")
		wr(INT_STATUS_ADDR, 32'h0000_000f);
	endtask : t_edges

	task automatic t_disabled_pins;
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_0000);
		wr(PIN_CFG_ADDR, 32'h0000_0005);
		raw(2'b01);
		`CHK(pin_oe[0], 1'b1, "pp routed oe")
		`CHK(pin_out[0], 1'b0, "disabled pin")
		raw(2'b00);
		rd(COMPARATOR0_CONTROL_ADDR, 32'h0000_0000, "disabled ctrl0");
		rd(INT_STATUS_ADDR, 32'h0000_0000, "disabled status");
		`CHK(irq, 1'b0, "disabled irq")
		wr(COMPARATOR0_CONTROL_ADDR, 32'h0000_0080);
		wait_stable(2'b11);
		raw(2'b01);
		`CHK(pin_out[0], 1'b1, "pp high")
		wr(PIN_CFG_ADDR, 32'h0000_0003);
		@(posedge ref_clk);
		`CHK(pin_oe, 2'b10, "od released")
		raw(2'b00);
		`CHK({pin_oe, pin_out}, 4'b1100, "od low")
		wr(INT_STATUS_ADDR, 32'h0000_000f);
	endtask : t_disabled_pins

	task automatic t_reset_source;
		wr(RESET_CFG_ADDR, 32'h0000_0001);
		rd(RESET_CFG_ADDR, 32'h0000_0001, "rstcfg rb");
		`CHK(reset_req, 1'b1, "cmp0 low req")
		raw(2'b01);
		`CHK(reset_req, 1'b0, "cmp0 high req")
		wr(RESET_CFG_ADDR, 32'h0000_0000);
		raw(2'b00);
		`CHK(reset_req, 1'b0, "source off")
	endtask : t_reset_source

	// ************************************************
	// Sequence and verdict
	// ************************************************
	task automatic close_out;
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	initial begin
		reset   = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 14'h0000;
		pwdata  = 32'h0000_0000;
		cmp_raw = 2'b00;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_reset_values();
		t_hysteresis();
		t_edges();
		t_disabled_pins();
		t_reset_source();
		close_out();
	end

	// Run needs a few hundred cycles; this is far beyond that
	initial begin
		#400us;
		miscompares++;
		close_out();
	end

endmodule : dcc_top_tb_top

`default_nettype wire
